// ### keyed_watchdog_timer.sv
// Keyed watchdog timer: clock selection, key check, flags and registers.
`timescale 1ns/1ps
`include "kwd_consts.svh"

// Overview of operation
// - Clock is sub clock or system clock/4
// - Sub clock from crystal or internal RC
// - Period select picks 2^8 to 2^18
// - Always-on: both valid keys run, others reset
// - Register control: 10101 off, 01010 on
// - Bad key resets after 2-3 RC cycles
// - Key loads 01010 at power-on
// - Key reset flag cleared only by software
// - Normal overflow resets device, sets timeout
// - Sleep overflow sets timeout, clears PC/SP
// - Key reset, clear or halt clears count
// - Flag register bits 6..3 read zero
// - Sleep overflow wakes device, starts reset
// - Power-down flag: halt sets, clear clears
module keyed_watchdog_timer
  import kwd_pkg::*;
#(
  parameter bit ALWAYS_ON     = 1'b0,
  parameter bit SRC_SYS_DIV4  = 1'b0,
  parameter bit SUB_FROM_LOW_SPEED_INTERNAL_RC = 1'b1
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Oscillator and supply monitor pins.
  input  wire logic        lowSpeedCrystal,
  input  wire logic        lowSpeedInternalRc,
  input  wire logic        lowVoltageEvent,
  input  wire logic        voltageSelectEvent,
  // Processor events.
  input  wire logic        clearWatchdogInstruction,
  input  wire logic        haltInstruction,
  input  wire logic        lowPowerMode,
  // Reset, wake and interrupt requests.
  output logic             deviceReset,
  output logic             pcSpReset,
  output logic             wakeUp,
  output logic             wdtIrq,
  // AXI4-Lite.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  localparam int NPIN = 4;

  kwd_reg_if regBus ();
  kwd_cnt_if cntBus ();

  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinEdge;
  logic [2:0]      pinSync [NPIN];
  logic [NPIN-1:0] pinStable;
  logic [NPIN-1:0] pinStableD;

  kwd_byte_t  wdtCtrl;
  kwd_byte_t  rfcReg;
  logic       timeoutFlag;
  logic       powerDownFlag;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [1:0] sysDiv;
  logic       sysTick;
  logic       subTick;
  logic       lircTick;
  logic       srcTick;
  logic [4:0] key;
  logic       keyValid;
  logic       wdtEnable;
  kwd_key_e   keyState;
  logic [1:0] keyTicks;
  logic       keyFire;
  logic       ovf;
  logic       wrCtrl;
  logic       wrRfc;
  logic       wrIrqSt;
  logic       wrIrqMsk;
  logic [31:0] next_rdData;

  // Register index from byte address; 3'h7 marks an unmapped word.
  function automatic logic [2:0] regIndex(input logic [7:0] addr);
    case (addr)
      `KWD_OFF_CTRL:    regIndex = 3'h0;
      `KWD_OFF_RFC:     regIndex = 3'h1;
      `KWD_OFF_STAT:    regIndex = 3'h2;
      `KWD_OFF_IRQ_ST:  regIndex = 3'h3;
      `KWD_OFF_IRQ_MSK: regIndex = 3'h4;
      `KWD_OFF_COUNT:   regIndex = 3'h5;
      default:          regIndex = 3'h7;
    endcase
  endfunction : regIndex

  assign pinRaw = {voltageSelectEvent, lowVoltageEvent, lowSpeedInternalRc, lowSpeedCrystal};

  // Pins are asynchronous; a level counts only once the last two stages agree.
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        pinSync[i]    <= 3'h0;
        pinStable[i]  <= 1'b0;
        pinStableD[i] <= 1'b0;
      end else begin
        pinSync[i]    <= {pinSync[i][1:0], pinRaw[i]};
        pinStableD[i] <= pinStable[i];
        if (pinSync[i][1] == pinSync[i][2]) begin
          pinStable[i] <= pinSync[i][2];
        end
      end
    end
    assign pinEdge[i] = pinStable[i] && !pinStableD[i];
  end

  // The system clock is ref_clk itself, so divide-by-four is a tick every fourth edge.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sysDiv <= 2'h0;
    end else begin
      sysDiv <= sysDiv + 2'h1;
    end
  end

  assign sysTick  = (sysDiv == `KWD_SYS_DIV_LAST);
  assign subTick  = SUB_FROM_LOW_SPEED_INTERNAL_RC ? pinEdge[1] : pinEdge[0];
  assign lircTick = pinEdge[1];

  // With the system clock as source, the count stops in low power unless the clock is kept.
  always_comb begin
    if (SRC_SYS_DIV4) begin
      srcTick = sysTick && (!lowPowerMode || rfcReg[`KWD_RFC_KEEP]);
    end else begin
      srcTick = subTick;
    end
  end

  assign key      = wdtCtrl[`KWD_KEY_MSB:`KWD_KEY_LSB];
  assign keyValid = (key == `KWD_KEY_ENABLE) || (key == `KWD_KEY_DISABLE);

  always_comb begin
    if (ALWAYS_ON) begin
      wdtEnable = keyValid;
    end else begin
      wdtEnable = (key == `KWD_KEY_ENABLE);
    end
  end

  // Once a bad key is seen the reset is committed, even if software repairs the key.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      keyState <= KS_IDLE;
      keyTicks <= 2'h0;
    end else begin
      case (keyState)
        KS_IDLE: begin
          keyTicks <= 2'h0;
          if (!keyValid) begin
            keyState <= KS_WAIT;
          end
        end
        KS_WAIT: begin
          if (lircTick) begin
            keyTicks <= keyTicks + 2'h1;
            if (keyTicks == `KWD_KEY_TICKS - 2'h1) begin
              keyState <= KS_FIRE;
            end
          end
        end
        KS_FIRE: begin
          keyState <= KS_IDLE;
        end
        default: begin
          keyState <= KS_IDLE;
        end
      endcase
    end
  end

  assign keyFire = (keyState == KS_FIRE);

  assign cntBus.tick   = srcTick;
  assign cntBus.enable = wdtEnable;
  assign cntBus.sel    = wdtCtrl[`KWD_SEL_MSB:0];
  assign cntBus.clear  = keyFire || clearWatchdogInstruction || haltInstruction;
  assign ovf           = cntBus.overflow;

  kwd_counter u_counter (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .c       (cntBus)
  );

  kwd_axil_slave u_bus (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .r       (regBus)
  );

  assign wrCtrl   = regBus.wrEn && regBus.wrByte0 && (regIndex(regBus.wrAddr) == 3'h0);
  assign wrRfc    = regBus.wrEn && regBus.wrByte0 && (regIndex(regBus.wrAddr) == 3'h1);
  assign wrIrqSt  = regBus.wrEn && regBus.wrByte0 && (regIndex(regBus.wrAddr) == 3'h3);
  assign wrIrqMsk = regBus.wrEn && regBus.wrByte0 && (regIndex(regBus.wrAddr) == 3'h4);
  assign regBus.wrOk = (regIndex(regBus.wrAddr) != 3'h7);
  assign regBus.rdOk = (regIndex(regBus.rdAddr) != 3'h7);

  // A key reset puts the control byte back to its power-on value.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wdtCtrl <= `KWD_CTRL_RST;
    end else if (keyFire) begin
      wdtCtrl <= `KWD_CTRL_RST;
    end else if (wrCtrl) begin
      wdtCtrl <= regBus.wrData[7:0];
    end
  end

  // Reset flags: hardware sets, software clears by writing zero; a set wins.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rfcReg <= 8'h00;
    end else begin
      if (wrRfc) begin
        rfcReg[`KWD_RFC_KEEP] <= regBus.wrData[`KWD_RFC_KEEP];
      end
      if (keyFire) begin
        rfcReg[`KWD_RFC_KRF] <= 1'b1;
      end else if (wrRfc && !regBus.wrData[`KWD_RFC_KRF]) begin
        rfcReg[`KWD_RFC_KRF] <= 1'b0;
      end
      if (pinEdge[2]) begin
        rfcReg[`KWD_RFC_LOW_VOLTAGE_RESET_FLAG] <= 1'b1;
      end else if (wrRfc && !regBus.wrData[`KWD_RFC_LOW_VOLTAGE_RESET_FLAG]) begin
        rfcReg[`KWD_RFC_LOW_VOLTAGE_RESET_FLAG] <= 1'b0;
      end
      if (pinEdge[3]) begin
        rfcReg[`KWD_RFC_LRF] <= 1'b1;
      end else if (wrRfc && !regBus.wrData[`KWD_RFC_LRF]) begin
        rfcReg[`KWD_RFC_LRF] <= 1'b0;
      end
      rfcReg[6:3] <= 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timeoutFlag <= 1'b0;
    end else if (ovf) begin
      timeoutFlag <= 1'b1;
    end else if (clearWatchdogInstruction || haltInstruction) begin
      timeoutFlag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      powerDownFlag <= 1'b0;
    end else if (haltInstruction) begin
      powerDownFlag <= 1'b1;
    end else if (clearWatchdogInstruction) begin
      powerDownFlag <= 1'b0;
    end
  end

  // Reset and wake requests are one-cycle pulses.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      deviceReset <= 1'b0;
      pcSpReset   <= 1'b0;
      wakeUp      <= 1'b0;
    end else begin
      deviceReset <= keyFire || (ovf && !lowPowerMode);
      pcSpReset   <= ovf && lowPowerMode;
      wakeUp      <= ovf && lowPowerMode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irqStatus <= 2'h0;
      irqMask   <= 2'h0;
    end else begin
      irqStatus[`KWD_IRQ_OVF] <= ovf || (irqStatus[`KWD_IRQ_OVF] &&
                                 !(wrIrqSt && regBus.wrData[`KWD_IRQ_OVF]));
      irqStatus[`KWD_IRQ_KEY] <= keyFire || (irqStatus[`KWD_IRQ_KEY] &&
                                 !(wrIrqSt && regBus.wrData[`KWD_IRQ_KEY]));
      if (wrIrqMsk) begin
        irqMask <= regBus.wrData[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wdtIrq <= 1'b0;
    end else begin
      wdtIrq <= |(irqStatus & irqMask);
    end
  end

  always_comb begin
    next_rdData = 32'h00000000;
    case (regIndex(regBus.rdAddr))
      3'h0:    next_rdData[7:0] = wdtCtrl;
      3'h1:    next_rdData[7:0] = {rfcReg[7], 4'h0, rfcReg[2:0]};
      3'h2:    next_rdData[1:0] = {powerDownFlag, timeoutFlag};
      3'h3:    next_rdData[1:0] = irqStatus;
      3'h4:    next_rdData[1:0] = irqMask;
      3'h5:    next_rdData[17:0] = cntBus.count;
      default: next_rdData = 32'h00000000;
    endcase
  end

  assign regBus.rdData = next_rdData;
endmodule : keyed_watchdog_timer

// ### kwd_assertions.sv
// Concurrent checks on the keyed watchdog top-level ports.
`timescale 1ns/1ps
module kwd_assertions (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Processor side.
  input wire logic        clearWatchdogInstruction,
  input wire logic        lowPowerMode,
  input wire logic        deviceReset,
  input wire logic        pcSpReset,
  input wire logic        wakeUp,
  // AXI4-Lite.
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  // Reset itself must quiet both reset requests and both responses, so this one is never disabled.
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !deviceReset && !pcSpReset && !bvalid && !rvalid)
    else $error("request or response active during reset");
  a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read response late");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response changed");
  a_unmapped_read: assert property (s_rd_taken ##0 (araddr > 8'h14) |=> rresp == 2'h2)
    else $error("unmapped read not refused");
  a_reset_pulse: assert property ($rose(deviceReset) |=> !deviceReset)
    else $error("device reset longer than one cycle");
  a_sleep_only: assert property (pcSpReset |-> $past(lowPowerMode) && !deviceReset)
    else $error("partial reset outside low power");
  a_wake_paired: assert property (pcSpReset || wakeUp |-> pcSpReset && wakeUp)
    else $error("wake and partial reset apart");
  a_clear_holds: assert property (clearWatchdogInstruction |-> ##3 (!pcSpReset && !deviceReset)[*8])
    else $error("overflow right after clear");
endmodule : kwd_assertions

bind keyed_watchdog_timer kwd_assertions u_kwd_assertions (
  .ref_clk(ref_clk), .rstn(rstn), .clearWatchdogInstruction(clearWatchdogInstruction),
  .lowPowerMode(lowPowerMode), .deviceReset(deviceReset), .pcSpReset(pcSpReset), .wakeUp(wakeUp),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);

// ### kwd_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into register strobes.
`timescale 1ns/1ps
`include "kwd_consts.svh"
module kwd_axil_slave (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // AXI4-Lite.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side.
  kwd_reg_if.slave         r
);
  logic awHeld;
  logic wHeld;

  assign r.wrEn   = awHeld && wHeld && !bvalid;
  assign r.rdAddr = araddr;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `KWD_RESP_OKAY;
      r.wrAddr  <= 8'h00;
      r.wrData  <= 32'h00000000;
      r.wrByte0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready  <= 1'b0;
        awHeld   <= 1'b1;
        r.wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        wHeld     <= 1'b1;
        r.wrData  <= wdata;
        r.wrByte0 <= wstrb[0];
      end
      if (r.wrEn) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= r.wrOk ? `KWD_RESP_OKAY : `KWD_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `KWD_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= r.rdData;
      rresp   <= r.rdOk ? `KWD_RESP_OKAY : `KWD_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : kwd_axil_slave

// ### kwd_consts.svh
// Offsets, field positions, reset values and counts of the keyed watchdog.
`ifndef KWD_CONSTS_SVH
`define KWD_CONSTS_SVH
`define KWD_OFF_CTRL     8'h00
`define KWD_OFF_RFC      8'h04
`define KWD_OFF_STAT     8'h08
`define KWD_OFF_IRQ_ST   8'h0c
`define KWD_OFF_IRQ_MSK  8'h10
`define KWD_OFF_COUNT    8'h14
`define KWD_CTRL_RST     8'h53
`define KWD_KEY_MSB      7
`define KWD_KEY_LSB      3
`define KWD_SEL_MSB      2
`define KWD_KEY_ENABLE   5'h0a
`define KWD_KEY_DISABLE  5'h15
`define KWD_RFC_KEEP     7
`define KWD_RFC_LOW_VOLTAGE_RESET_FLAG     2
`define KWD_RFC_LRF      1
`define KWD_RFC_KRF      0
`define KWD_STAT_TO      0
`define KWD_STAT_PDF     1
`define KWD_IRQ_OVF      0
`define KWD_IRQ_KEY      1
`define KWD_SYS_DIV_LAST 2'h3
`define KWD_KEY_TICKS    2'h3
`define KWD_RESP_OKAY    2'h0
`define KWD_RESP_SLVERR  2'h2
`endif

// ### kwd_counter.sv
// Timeout counter with power-of-two period select.
`timescale 1ns/1ps
module kwd_counter
  import kwd_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Control link.
  kwd_cnt_if.cnt    c
);
  kwd_count_t count;
  logic       hit;

  function automatic kwd_count_t lastCount(input logic [2:0] sel);
    case (sel)
      3'h0:    lastCount = 18'h000ff;
      3'h1:    lastCount = 18'h003ff;
      3'h2:    lastCount = 18'h00fff;
      3'h3:    lastCount = 18'h03fff;
      3'h4:    lastCount = 18'h07fff;
      3'h5:    lastCount = 18'h0ffff;
      3'h6:    lastCount = 18'h1ffff;
      default: lastCount = 18'h3ffff;
    endcase
  endfunction : lastCount

  assign hit = (count == lastCount(c.sel));

  always_ff @(posedge ref_clk) begin
    if (!rstn || c.clear || !c.enable) begin
      count <= 18'h00000;
    end else if (c.tick) begin
      count <= hit ? 18'h00000 : count + 18'h00001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      c.overflow <= 1'b0;
    end else begin
      c.overflow <= c.tick && c.enable && !c.clear && hit;
    end
  end

  assign c.count = count;
endmodule : kwd_counter

// ### kwd_if.sv
// Internal carriers: register access strobes and the timeout counter link.
`timescale 1ns/1ps
interface kwd_reg_if;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic        wrByte0;
  logic        wrEn;
  logic        wrOk;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  logic        rdOk;
  modport slave (output wrAddr, wrData, wrByte0, wrEn, rdAddr, input wrOk, rdData, rdOk);
  modport regs  (input wrAddr, wrData, wrByte0, wrEn, rdAddr, output wrOk, rdData, rdOk);
endinterface : kwd_reg_if

interface kwd_cnt_if;
  logic        tick;
  logic        clear;
  logic        enable;
  logic [2:0]  sel;
  logic        overflow;
  logic [17:0] count;
  modport ctl (output tick, clear, enable, sel, input overflow, count);
  modport cnt (input tick, clear, enable, sel, output overflow, count);
endinterface : kwd_cnt_if

// ### kwd_pkg.sv
// Types shared by the keyed watchdog modules.
package kwd_pkg;
  typedef enum logic [2:0] {
    KS_IDLE = 3'b001,
    KS_WAIT = 3'b010,
    KS_FIRE = 3'b100
  } kwd_key_e;
  typedef logic [7:0]  kwd_byte_t;
  typedef logic [17:0] kwd_count_t;
endpackage : kwd_pkg

// ### tb.sv
// Self-checking bench for the keyed watchdog timer.
`timescale 1ns/1ps
`include "kwd_consts.svh"
module tb;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        lowSpeedInternalRc = 1'b0;
  logic        lowSpeedCrystal = 1'b0;
  logic        altDeviceReset;
  logic        lowVoltageEvent, voltageSelectEvent, clearWatchdogInstruction, haltInstruction, lowPowerMode;
  logic        deviceReset, pcSpReset, wakeUp, wdtIrq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc;

  // The system-clock source keeps overflow periods short enough to measure.
  keyed_watchdog_timer #(.ALWAYS_ON(1'b0), .SRC_SYS_DIV4(1'b1), .SUB_FROM_LOW_SPEED_INTERNAL_RC(1'b1)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .lowSpeedCrystal(lowSpeedCrystal), .lowSpeedInternalRc(lowSpeedInternalRc),
    .lowVoltageEvent(lowVoltageEvent), .voltageSelectEvent(voltageSelectEvent),
    .clearWatchdogInstruction(clearWatchdogInstruction), .haltInstruction(haltInstruction),
    .lowPowerMode(lowPowerMode), .deviceReset(deviceReset), .pcSpReset(pcSpReset), .wakeUp(wakeUp),
    .wdtIrq(wdtIrq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  // A second build, always on and fed by the crystal pin, shares every input with the first.
  keyed_watchdog_timer #(.ALWAYS_ON(1'b1), .SRC_SYS_DIV4(1'b0), .SUB_FROM_LOW_SPEED_INTERNAL_RC(1'b0)) dut_alt (
    .ref_clk(ref_clk), .rstn(rstn), .lowSpeedCrystal(lowSpeedCrystal), .lowSpeedInternalRc(lowSpeedInternalRc),
    .lowVoltageEvent(lowVoltageEvent), .voltageSelectEvent(voltageSelectEvent),
    .clearWatchdogInstruction(clearWatchdogInstruction), .haltInstruction(haltInstruction),
    .lowPowerMode(lowPowerMode), .deviceReset(altDeviceReset), .pcSpReset(), .wakeUp(), .wdtIrq(),
    .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(), .bresp(), .bvalid(), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(),
    .rdata(), .rresp(), .rvalid(), .rready(rready)
  );

  always #5 ref_clk = ~ref_clk;

  // The crystal pin runs at a period of 8 clock cycles.
  always begin
    repeat (4) @(posedge ref_clk);
    lowSpeedCrystal <= ~lowSpeedCrystal;
  end

  // The RC pin runs at a period of 16 clock cycles; it also times the bad-key delay.
  always begin
    repeat (8) @(posedge ref_clk);
    lowSpeedInternalRc <= ~lowSpeedInternalRc;
  end

  task automatic give_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic hang(input bit ok);
    if (!ok) begin
      n_errors++;
      $display("ERROR wait expected done seen timeout");
      give_verdict();
    end
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
                    input logic [3:0] s = 4'h1);
    bit ok;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      ok = (bvalid === 1'b1);
      if (ok) chk("bresp", bresp, er);
    end
    bready <= 1'b0;
    @(posedge ref_clk);
    hang(ok);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0,
                    input logic [31:0] m = 32'hffffffff);
    bit ok;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      ok = (rvalid === 1'b1);
      if (ok) chk($sformatf("read %h", a), rdata & m, exp);
      if (ok) chk("rresp", rresp, er);
    end
    rready <= 1'b0;
    @(posedge ref_clk);
    hang(ok);
  endtask : rd

  // Kind 0 clear, 1 halt: one-cycle pulses. Kinds 2 and 3: levels long enough to pass the synchronizer.
  task automatic ev(input int k);
    clearWatchdogInstruction <= (k == 0);
    haltInstruction <= (k == 1);
    lowVoltageEvent <= (k == 2);
    voltageSelectEvent <= (k == 3);
    @(posedge ref_clk);
    clearWatchdogInstruction <= 1'b0;
    haltInstruction <= 1'b0;
    repeat (6) @(posedge ref_clk);
    lowVoltageEvent <= 1'b0;
    voltageSelectEvent <= 1'b0;
  endtask : ev

  // Kind 0 waits for the full reset, 1 for the partial reset, 2 for the second build's full reset.
  task automatic wait_evt(input int slp, input int lim);
    bit hit;
    cyc = 0;
    while (!hit && cyc < lim) begin
      @(posedge ref_clk);
      cyc++;
      hit = (slp == 1) ? (pcSpReset === 1'b1) : (slp == 2) ? (altDeviceReset === 1'b1) : (deviceReset === 1'b1);
      if (slp == 1 && hit) chk("wakeUp", wakeUp, 1'b1);
    end
    hang(hit);
  endtask : wait_evt

  initial begin
    int e;
    {lowVoltageEvent, voltageSelectEvent, clearWatchdogInstruction, haltInstruction, lowPowerMode} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`KWD_OFF_CTRL, 32'h53);
    rd(`KWD_OFF_RFC, 32'h0);
    rd(`KWD_OFF_STAT, 32'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'hff, 2'h2);
    wr(`KWD_OFF_CTRL, 32'ha8, 2'h0, 4'h0);
    rd(`KWD_OFF_CTRL, 32'h53);
    wr(`KWD_OFF_CTRL, 32'ha8);
    repeat (40) @(posedge ref_clk);
    rd(`KWD_OFF_COUNT, 32'h0);
    ev(0);
    wait_evt(2, 3000);
    chk("alt_ovf_cycles", (cyc >= 2024 && cyc <= 2064), 1'b1);
    wr(`KWD_OFF_RFC, 32'hff);
    rd(`KWD_OFF_RFC, 32'h80);
    wr(`KWD_OFF_RFC, 32'h0);
    for (int s = 0; s < 3; s++) begin
      e = 4 << (8 + 2 * s);
      wr(`KWD_OFF_CTRL, 32'h50 | s);
      ev(0);
      wait_evt(1'b0, 20000);
      chk("ovf_cycles", (cyc >= e - 16 && cyc <= e + 8), 1'b1);
    end
    rd(`KWD_OFF_STAT, 32'h1);
    rd(`KWD_OFF_IRQ_ST, 32'h1);
    chk("wdtIrq", wdtIrq, 1'b0);
    wr(`KWD_OFF_IRQ_MSK, 32'h3);
    chk("wdtIrq", wdtIrq, 1'b1);
    wr(`KWD_OFF_IRQ_ST, 32'h1);
    chk("wdtIrq", wdtIrq, 1'b0);
    ev(1);
    rd(`KWD_OFF_STAT, 32'h2);
    rd(`KWD_OFF_COUNT, 32'h0, 2'h0, 32'h3fff0);
    ev(0);
    rd(`KWD_OFF_STAT, 32'h0);
    wr(`KWD_OFF_CTRL, 32'h50);
    lowPowerMode <= 1'b1;
    ev(0);
    repeat (40) @(posedge ref_clk);
    rd(`KWD_OFF_COUNT, 32'h0);
    wr(`KWD_OFF_RFC, 32'h80);
    wait_evt(1, 2000);
    lowPowerMode <= 1'b0;
    rd(`KWD_OFF_STAT, 32'h1);
    wr(`KWD_OFF_RFC, 32'h0);
    wr(`KWD_OFF_CTRL, 32'ha8);
    ev(2);
    ev(3);
    rd(`KWD_OFF_RFC, 32'h6);
    wr(`KWD_OFF_IRQ_ST, 32'h3);
    wr(`KWD_OFF_CTRL, 32'h0);
    wait_evt(1'b0, 200);
    chk("key_delay", (cyc >= 24 && cyc <= 60), 1'b1);
    rd(`KWD_OFF_RFC, 32'h7);
    rd(`KWD_OFF_CTRL, 32'h53);
    rd(`KWD_OFF_IRQ_ST, 32'h2);
    chk("wdtIrq", wdtIrq, 1'b1);
    wr(`KWD_OFF_RFC, 32'h7);
    rd(`KWD_OFF_RFC, 32'h7);
    wr(`KWD_OFF_RFC, 32'h0);
    rd(`KWD_OFF_RFC, 32'h0);
    give_verdict();
  end
endmodule : tb
